// file: logic/link_msg_pkg.sv
// Shared codes, characters, types and helpers for the remote message link
package link_msg_pkg;

  // ==========================================
  // Framing characters
  localparam logic [7:0] CH_BSL = 8'h5c;
  localparam logic [7:0] CH_CR = 8'h0d;
  localparam logic [7:0] CH_ACK = 8'h06;
  localparam logic [7:0] CH_NAK = 8'h15;
  localparam logic [7:0] CH_ENQ = 8'h05;
  localparam logic [7:0] CH_SOH = 8'h01;

  // ==========================================
  // Message codes
  localparam logic [7:0] CODE_TEXT = 8'h80;
  localparam logic [7:0] CODE_KEYCHK = 8'h8a;
  localparam logic [7:0] CODE_RETX = 8'hf6;
  localparam logic [7:0] CODE_ABORT = 8'hf7;
  localparam logic [7:0] CODE_NEXT = 8'hf8;
  localparam logic [7:0] CODE_KEY = 8'hf9;
  localparam logic [7:0] CODE_END = 8'hf1;

  // ==========================================
  // Reset values
  localparam logic [7:0] TX_DATA_RST = 8'h00;
  localparam logic [7:0] CODE_RST = 8'h00;

  // ==========================================
  // Kinds of outgoing message
  typedef enum logic [2:0] {
    KIND_TEXT = 3'b000,
    KIND_RETX = 3'b001,
    KIND_ABORT = 3'b010,
    KIND_KEYCHK = 3'b011,
    KIND_NEXT = 3'b100
  } msg_kind_t;

  // Parsed reply from the host
  typedef struct packed {
    logic [7:0] code;
    logic [7:0] arg;
    logic has_arg;
  } reply_t;

  // Raw object record byte from the host
  typedef struct packed {
    logic [7:0] data;
    logic last;
  } rec_byte_t;

  // ==========================================
  // Helpers
  function automatic logic [7:0] hex_char(input logic [3:0] nib);
    hex_char = (nib < 4'ha) ? (8'h30 + {4'h0, nib}) : (8'h37 + {4'h0, nib});
  endfunction : hex_char

  function automatic logic [3:0] hex_val(input logic [7:0] ch);
    if (ch >= 8'h61) begin
      hex_val = 4'(ch - 8'h57);
    end else if (ch >= 8'h41) begin
      hex_val = 4'(ch - 8'h37);
    end else begin
      hex_val = 4'(ch - 8'h30);
    end
  endfunction : hex_val

  function automatic logic [7:0] code_of(input msg_kind_t k);
    unique case (k)
      KIND_TEXT: code_of = CODE_TEXT;
      KIND_RETX: code_of = CODE_RETX;
      KIND_ABORT: code_of = CODE_ABORT;
      KIND_KEYCHK: code_of = CODE_KEYCHK;
      KIND_NEXT: code_of = CODE_NEXT;
      default: code_of = CODE_NEXT;
    endcase
  endfunction : code_of

endpackage : link_msg_pkg

// file: logic/reply_parser.sv
// Splits the incoming byte stream into host replies and raw object records
`timescale 1ns/1ps
module reply_parser (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  // Incoming bytes
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  // Parsed output
  output link_msg_pkg::reply_t reply,
  output logic reply_valid,
  output link_msg_pkg::rec_byte_t rec,
  output logic rec_valid
);

  typedef enum logic [2:0] {
    P_START = 3'b000,
    P_HI = 3'b001,
    P_LO = 3'b010,
    P_ARG = 3'b011,
    P_REST = 3'b100,
    P_REC = 3'b101
  } pstate_t;

  pstate_t st_r;
  logic [3:0] hi_r;
  link_msg_pkg::reply_t cur_r;

  wire is_cr = (rx_data == link_msg_pkg::CH_CR);
  wire is_bsl = (rx_data == link_msg_pkg::CH_BSL);
  wire take = ce && rx_valid;

  // ==========================================
  // Line parser
  always_ff @(posedge mclk) begin
    if (rst) begin
      st_r <= P_START;
      hi_r <= 4'h0;
      cur_r <= '0;
      reply <= '0;
      reply_valid <= 1'b0;
      rec <= '0;
      rec_valid <= 1'b0;
    end else if (ce) begin
      reply_valid <= 1'b0;
      rec_valid <= 1'b0;
      if (take) begin
        unique case (st_r)
          P_START: begin
            if (is_bsl) begin
              st_r <= P_HI;
            end else if (!is_cr) begin
              rec <= '{data: rx_data, last: 1'b0};
              rec_valid <= 1'b1;
              st_r <= P_REC;
            end
          end
          P_HI: begin
            hi_r <= link_msg_pkg::hex_val(rx_data);
            st_r <= P_LO;
          end
          P_LO: begin
            cur_r <= '{code: {hi_r, link_msg_pkg::hex_val(rx_data)}, arg: 8'h00, has_arg: 1'b0};
            st_r <= P_ARG;
          end
          P_ARG, P_REST: begin
            if (is_cr) begin
              reply <= cur_r;
              reply_valid <= 1'b1;
              st_r <= P_START;
            end else if (st_r == P_ARG) begin
              // Only the first text character is kept
              cur_r.arg <= rx_data;
              cur_r.has_arg <= 1'b1;
              st_r <= P_REST;
            end
          end
          P_REC: begin
            rec <= '{data: rx_data, last: is_cr};
            rec_valid <= 1'b1;
            if (is_cr) begin
              st_r <= P_START;
            end
          end
          default: st_r <= P_START;
        endcase
      end
    end
  end

endmodule : reply_parser

// file: logic/msg_engine.sv
// Device end of the remote text display and object load/verify exchange
`timescale 1ns/1ps
module msg_engine (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  // Link bytes out
  output logic tx_valid,
  output logic [7:0] tx_data,
  input wire logic tx_ready,
  // Link bytes in
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  // Message request
  input wire logic req_valid,
  input wire link_msg_pkg::msg_kind_t req_kind,
  input wire logic req_scroll,
  output logic req_ready,
  output logic req_dropped,
  // Text body for text messages
  input wire logic txt_valid,
  input wire logic [7:0] txt_data,
  input wire logic txt_last,
  output logic txt_ready,
  // Mode
  input wire logic load_active,
  input wire logic cmd_start,
  // Results
  output logic xchg_done,
  output logic [7:0] host_code,
  output logic scroll_stopped,
  output logic load_abort,
  output logic load_end,
  output logic key_valid,
  output logic [7:0] key_char,
  output link_msg_pkg::rec_byte_t rec,
  output logic rec_valid
);

  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_BSL = 3'b001,
    S_HI = 3'b010,
    S_LO = 3'b011,
    S_TXT = 3'b100,
    S_CR = 3'b101,
    S_WAIT = 3'b110
  } state_t;

  state_t st_r;
  link_msg_pkg::msg_kind_t kind_r;
  logic scroll_r;
  logic stop_r;
  logic [7:0] code_r;
  link_msg_pkg::reply_t reply;
  logic reply_valid;

  // ==========================================
  // Reply parser
  reply_parser u_parser (
    .mclk(mclk),
    .rst(rst),
    .ce(ce),
    .rx_valid(rx_valid),
    .rx_data(rx_data),
    .reply(reply),
    .reply_valid(reply_valid),
    .rec(rec),
    .rec_valid(rec_valid)
  );

  // ==========================================
  // Decode
  wire slot_free = !tx_valid || tx_ready;
  assign req_ready = ce && (st_r == S_IDLE);
  wire req_take = req_valid && req_ready;
  wire req_refuse = req_take && (req_kind == link_msg_pkg::KIND_TEXT) && stop_r;
  wire txt_bad = (txt_data == link_msg_pkg::CH_ACK) || (txt_data == link_msg_pkg::CH_NAK) ||
                 (txt_data == link_msg_pkg::CH_ENQ) || (txt_data == link_msg_pkg::CH_SOH) ||
                 (txt_data == link_msg_pkg::CH_CR);
  assign txt_ready = ce && (st_r == S_TXT) && slot_free;
  wire txt_take = txt_valid && txt_ready;
  wire rec_done = rec_valid && rec.last;
  wire wait_end = (st_r == S_WAIT) && (reply_valid || rec_done);
  wire rcv_abort = reply.code == link_msg_pkg::CODE_ABORT;
  wire rcv_key = reply.code == link_msg_pkg::CODE_KEY;
  wire rcv_end = reply.code == link_msg_pkg::CODE_END;
  wire kind_text = kind_r == link_msg_pkg::KIND_TEXT;
  wire kind_load = (kind_r == link_msg_pkg::KIND_RETX) || (kind_r == link_msg_pkg::KIND_NEXT);
  wire stop_set = wait_end && reply_valid && kind_text && scroll_r && rcv_abort;

  // ==========================================
  // Sequencer
  always_ff @(posedge mclk) begin
    if (rst) begin
      st_r <= S_IDLE;
      kind_r <= link_msg_pkg::KIND_TEXT;
      scroll_r <= 1'b0;
      code_r <= link_msg_pkg::CODE_RST;
      tx_valid <= 1'b0;
      tx_data <= link_msg_pkg::TX_DATA_RST;
    end else if (ce) begin
      if (tx_valid && tx_ready) begin
        tx_valid <= 1'b0;
      end
      unique case (st_r)
        S_IDLE: begin
          if (req_take && !req_refuse) begin
            kind_r <= req_kind;
            scroll_r <= req_scroll;
            code_r <= link_msg_pkg::code_of(req_kind);
            st_r <= S_BSL;
          end
        end
        S_BSL: begin
          if (slot_free) begin
            tx_data <= link_msg_pkg::CH_BSL;
            tx_valid <= 1'b1;
            st_r <= S_HI;
          end
        end
        S_HI: begin
          if (slot_free) begin
            tx_data <= link_msg_pkg::hex_char(code_r[7:4]);
            tx_valid <= 1'b1;
            st_r <= S_LO;
          end
        end
        S_LO: begin
          if (slot_free) begin
            tx_data <= link_msg_pkg::hex_char(code_r[3:0]);
            tx_valid <= 1'b1;
            // text body only on text records
            st_r <= kind_text ? S_TXT : S_CR;
          end
        end
        S_TXT: begin
          if (txt_take) begin
            if (!txt_bad) begin
              tx_data <= txt_data;
              tx_valid <= 1'b1;
            end
            if (txt_last) begin
              st_r <= S_CR;
            end
          end
        end
        S_CR: begin
          if (slot_free) begin
            tx_data <= link_msg_pkg::CH_CR;
            tx_valid <= 1'b1;
            st_r <= S_WAIT;
          end
        end
        S_WAIT: begin
          if (wait_end) begin
            st_r <= S_IDLE;
          end
        end
        default: st_r <= S_IDLE;
      endcase
    end
  end

  // ==========================================
  // Reply effects
  always_ff @(posedge mclk) begin
    if (rst) begin
      stop_r <= 1'b0;
      xchg_done <= 1'b0;
      host_code <= link_msg_pkg::CODE_RST;
      load_abort <= 1'b0;
      load_end <= 1'b0;
      key_valid <= 1'b0;
      key_char <= link_msg_pkg::CODE_RST;
      req_dropped <= 1'b0;
    end else if (ce) begin
      xchg_done <= wait_end;
      req_dropped <= req_refuse;
      load_abort <= 1'b0;
      load_end <= 1'b0;
      key_valid <= 1'b0;
      if (stop_set) begin
        stop_r <= 1'b1;
      end else if (cmd_start) begin
        stop_r <= 1'b0;
      end
      if (wait_end && reply_valid) begin
        host_code <= reply.code;
        load_abort <= load_active && rcv_abort && (kind_r != link_msg_pkg::KIND_ABORT);
        load_end <= kind_load && rcv_end;
        if ((kind_r == link_msg_pkg::KIND_KEYCHK) && rcv_key) begin
          key_valid <= 1'b1;
          key_char <= reply.has_arg ? reply.arg : link_msg_pkg::CODE_RST;
        end
      end
    end
  end

  assign scroll_stopped = stop_r;

endmodule : msg_engine

// file: tb/msg_engine_asserts.sv
// Port-level checks of the message engine
`timescale 1ns/1ps
module msg_engine_asserts (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  // Link out
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic tx_ready,
  // Requests and results
  input wire logic req_valid,
  input wire link_msg_pkg::msg_kind_t req_kind,
  input wire logic req_ready,
  input wire logic req_dropped,
  input wire logic xchg_done,
  input wire logic [7:0] host_code,
  input wire logic scroll_stopped
);
  default clocking @(posedge mclk);
  endclocking
  default disable iff (rst);
  wire take = req_valid && req_ready && ce;
  wire stop = req_kind == 3'h0 && scroll_stopped;
  wire acc = tx_valid && tx_ready && ce;
  // ==========================================
  // Properties
  property p_frame;
    take && !stop |-> ##2 tx_valid && tx_data == 8'h5c;
  endproperty
  a_frame: assert property (p_frame) else $error("frame start");
  property p_text;
    take && req_kind == 3'h0 && !scroll_stopped |-> ##[3:40] acc && tx_data == 8'h38;
  endproperty
  a_text: assert property (p_text) else $error("text code");
  property p_ctl;
    tx_valid |-> !(tx_data inside {8'h06, 8'h15, 8'h05, 8'h01});
  endproperty
  a_ctl: assert property (p_ctl) else $error("control char sent");
  property p_busy;
    take && !stop |=> !req_ready [*3];
  endproperty
  a_busy: assert property (p_busy) else $error("second request open");
  property p_drop;
    take && stop |=> req_dropped && !tx_valid ##1 !tx_valid [*3];
  endproperty
  a_drop: assert property (p_drop) else $error("text after stop");
  property p_stop;
    $rose(scroll_stopped) |-> xchg_done && host_code == 8'hf7;
  endproperty
  a_stop: assert property (p_stop) else $error("stop cause");
  property p_retx;
    take && req_kind == 3'h1 |-> ##[3:40] acc && tx_data == 8'h36;
  endproperty
  a_retx: assert property (p_retx) else $error("resend code");
  property p_abort;
    take && req_kind == 3'h2 |-> ##[3:40] acc && tx_data == 8'h37;
  endproperty
  a_abort: assert property (p_abort) else $error("abort code");
endmodule : msg_engine_asserts

bind msg_engine msg_engine_asserts u_chk (
  .mclk(mclk),
  .rst(rst),
  .ce(ce),
  .tx_valid(tx_valid),
  .tx_data(tx_data),
  .tx_ready(tx_ready),
  .req_valid(req_valid),
  .req_kind(req_kind),
  .req_ready(req_ready),
  .req_dropped(req_dropped),
  .xchg_done(xchg_done),
  .host_code(host_code),
  .scroll_stopped(scroll_stopped)
);

// file: tb/host_model.sv
// Host side of the link: answers each device message
`timescale 1ns/1ps
module host_model (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Device link
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  output logic tx_ready,
  output logic rx_valid,
  output logic [7:0] rx_data,
  // Operator and pacing
  input wire logic slow,
  input wire logic esc,
  input wire logic key_hit,
  input wire logic [7:0] key_in
);
  logic [7:0] ln[$];
  logic [7:0] q[$];
  logic sent;
  task automatic put(input string s);
    for (int i = 0; i < s.len(); i++) q.push_back(s[i]);
  endtask : put
  initial begin
    tx_ready = 1'h0;
    rx_valid = 1'h0;
    rx_data = 8'h00;
    sent = 1'h0;
  end
  // ==========================================
  // One reply per device line
  always @(posedge mclk) begin
    tx_ready <= slow ? ~tx_ready : 1'h1;
    rx_valid <= q.size() > 0;
    // Idle line inverts every bit of rx_data on each cycle, so it toggles around its last byte
    if (q.size() > 0) rx_data <= q.pop_front();
    else rx_data <= ~rx_data;
    if (rst) begin
      ln.delete();
      q.delete();
      sent = 1'h0;
    end else if (tx_valid && tx_ready && tx_data != 8'h0d) ln.push_back(tx_data);
    else if (tx_valid && tx_ready) begin
      case ({ln[1], ln[2]})
        "80": put(esc ? "\\F7\015" : "\\F8\015");
        "8A": begin
          if (esc) put("\\F7\015");
          else if (key_hit) begin
            put("\\F9");
            q.push_back(key_in);
            put("\015");
          end else put("\\F8\015");
        end
        "F6": put(":01\015");
        // next record, else end after closing
        "F8": begin
          if (sent) put("\\F1\015");
          else put(":01\015");
          sent = 1'h1;
        end
        default: put("\\F8\015");
      endcase
      ln.delete();
    end
  end
endmodule : host_model

// file: tb/remote_text_and_load_protocol_tb.sv
// Self-checking bench for the message engine
`timescale 1ns/1ps
module remote_text_and_load_protocol_tb;
  typedef struct packed {
    logic ld, sc, es, kh;
    logic [3:0] k;
    logic [7:0] cd, ex;
    logic [3:0] sn;
  } row_t;
  // Mode bits, kind, code sent, reply, {abort,end,key,record}
  row_t rows[10] = '{28'h0080f80, 28'h1080f80, 28'h938af92, 28'h838af80, 28'h84f8f81,
    28'h81f6f81, 28'h84f8f14, 28'ha080f78, 28'ha38af78, 28'h82f7f80};
  logic mclk, rst, req_valid, req_scroll, load_active, cmd_start, esc, key_hit, slow;
  logic ce = 1'h1;
  logic txt_valid = 1'h1;
  logic [7:0] key_in = 8'h6b;
  link_msg_pkg::msg_kind_t req_kind;
  link_msg_pkg::rec_byte_t rec;
  logic [1:0] ti;
  logic [3:0] seen;
  logic [7:0] txq[$];
  int num_errors, num_checks;
  wire tx_valid, tx_ready, rx_valid, req_ready, req_dropped, txt_ready, xchg_done;
  wire scroll_stopped, load_abort, load_end, key_valid, rec_valid;
  wire [7:0] tx_data, rx_data, host_code, key_char;
  wire [7:0] txt_data = ti == 2'h0 ? 8'h41 : ti == 2'h1 ? 8'h01 : 8'h42;
  wire txt_last = ti == 2'h2;
  msg_engine i_dut (
    .mclk(mclk),
    .rst(rst),
    .ce(ce),
    .tx_valid(tx_valid),
    .tx_data(tx_data),
    .tx_ready(tx_ready),
    .rx_valid(rx_valid),
    .rx_data(rx_data),
    .req_valid(req_valid),
    .req_kind(req_kind),
    .req_scroll(req_scroll),
    .req_ready(req_ready),
    .req_dropped(req_dropped),
    .txt_valid(txt_valid),
    .txt_data(txt_data),
    .txt_last(txt_last),
    .txt_ready(txt_ready),
    .load_active(load_active),
    .cmd_start(cmd_start),
    .xchg_done(xchg_done),
    .host_code(host_code),
    .scroll_stopped(scroll_stopped),
    .load_abort(load_abort),
    .load_end(load_end),
    .key_valid(key_valid),
    .key_char(key_char),
    .rec(rec),
    .rec_valid(rec_valid)
  );
  host_model i_host (
    .mclk(mclk),
    .rst(rst),
    .tx_valid(tx_valid),
    .tx_data(tx_data),
    .tx_ready(tx_ready),
    .rx_valid(rx_valid),
    .rx_data(rx_data),
    .slow(slow),
    .esc(esc),
    .key_hit(key_hit),
    .key_in(key_in)
  );
  initial begin
    mclk = 1'h0;
    forever #4 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    if (rst) ti <= 2'h0;
    else if (txt_ready) ti <= ti == 2'h2 ? 2'h0 : ti + 2'h1;
    if (tx_valid && tx_ready) txq.push_back(tx_data);
    if (req_valid && req_ready) seen <= 4'h0;
    if (load_abort) seen[3] <= 1'h1;
    if (load_end) seen[2] <= 1'h1;
    if (key_valid) seen[1] <= 1'h1;
    if (rec_valid && rec.last) seen[0] <= 1'h1;
  end
  // ==========================================
  // Tasks
  function automatic logic [7:0] hx(input logic [3:0] n);
    return n < 4'ha ? 8'h30 + 8'(n) : 8'h37 + 8'(n);
  endfunction : hx
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : wrap_up
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic xchg(input row_t r);
    logic [7:0] e[$];
    int n;
    @(posedge mclk);
    load_active <= r.ld;
    req_scroll <= r.sc;
    esc <= r.es;
    key_hit <= r.kh;
    req_kind <= link_msg_pkg::msg_kind_t'(r.k[2:0]);
    req_valid <= 1'h1;
    txq.delete();
    @(posedge mclk);
    req_valid <= 1'h0;
    n = 0;
    while (xchg_done !== 1'h1) begin
      @(posedge mclk);
      n++;
      if (n > 300) begin
        num_errors++;
        wrap_up();
      end
    end
    @(posedge mclk);
    e = {8'h5c, hx(r.cd[7:4]), hx(r.cd[3:0])};
    if (r.k == 4'h0) e = {e, 8'h41, 8'h42};
    e.push_back(8'h0d);
    chk("tx_count", 8'(e.size()), 8'(txq.size()));
    foreach (e[i]) chk("tx_byte", e[i], txq[i]);
    chk("host_code", r.ex, host_code);
    chk("effects", {4'h0, r.sn}, {4'h0, seen});
    if (r.sn[1]) chk("key_char", key_in, key_char);
    if (r.sn[0]) chk("rec_data", 8'h0d, rec.data);
  endtask : xchg
  initial begin
    rst = 1'h1;
    req_valid = 1'h0;
    req_kind = link_msg_pkg::KIND_TEXT;
    req_scroll = 1'h0;
    load_active = 1'h0;
    cmd_start = 1'h0;
    esc = 1'h0;
    key_hit = 1'h0;
    slow = 1'h0;
    repeat (3) @(posedge mclk);
    rst <= 1'h0;
    foreach (rows[i]) begin
      slow <= i[0];
      xchg(rows[i]);
      $display("row %0d done", i);
    end
    xchg(28'h6080f70);
    chk("scroll_stopped", 8'h01, 8'(scroll_stopped));
    req_valid <= 1'h1;
    txq.delete();
    @(posedge mclk);
    req_valid <= 1'h0;
    @(posedge mclk);
    chk("req_dropped", 8'h01, 8'(req_dropped));
    repeat (10) @(posedge mclk);
    chk("tx_count", 8'h00, 8'(txq.size()));
    cmd_start <= 1'h1;
    @(posedge mclk);
    cmd_start <= 1'h0;
    @(posedge mclk);
    chk("scroll_stopped", 8'h00, 8'(scroll_stopped));
    $display("scroll stop test done");
    ce <= 1'h0;
    @(posedge mclk);
    chk("req_ready", 8'h00, 8'(req_ready));
    chk("txt_ready", 8'h00, 8'(txt_ready));
    ce <= 1'h1;
    req_scroll <= 1'h0;
    req_valid <= 1'h1;
    @(posedge mclk);
    req_valid <= 1'h0;
    repeat (2) @(posedge mclk);
    rst <= 1'h1;
    repeat (3) @(posedge mclk);
    chk("tx_valid", 8'h00, 8'(tx_valid));
    chk("host_code", 8'h00, host_code);
    chk("req_ready", 8'h01, 8'(req_ready));
    rst <= 1'h0;
    xchg(rows[0]);
    $display("reset test done");
    wrap_up();
  end
endmodule : remote_text_and_load_protocol_tb
